// ### rtl/dea_ctrl.sv
// APB controller giving byte access to the nonvolatile data array.
//
// Overview of operation
// - Byte-wide 1024-location array, separate storage.
// - Address is high two bits plus low byte.
// - Each array write erases byte, then self-timed program.
// - Program select bit picks flash or array.
// - Config select bit overrides, picks config space.
// - Write permit gates writes, cleared at reset.
// - Abort flag on reset-cut or improper write.
// - Space selects untouched when abort occurs.
// - Write start set-only, hardware clears at end.
// - Write-done flag set at completion, sticky.
// - Row erase bit clears when a flash-space write completes.
// - Read start only with both selects zero.
// - Data loads next cycle, held until changed.
// - Key register has no storage, reads zero.
// - Start needs key 55 then AA first.
// - Permit must predate the start request.
// - Busy write locks control, address, data.
// - No writes during the power-up timer.
module dea_ctrl #(
  parameter int unsigned WRITE_CYCLES = dea_pkg::WRITE_CYCLES,
  parameter int unsigned PWRT_CYCLES = dea_pkg::PWRT_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [dea_pkg::PADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic abort_reset,
  output logic flash_op_busy,
  output logic config_op_busy,
  output logic row_erase_active,
  output logic irq_req,
  output logic irq_high_prio
);

  // Control register fields.
  logic pgm_sel_ff;
  logic cfg_sel_ff;
  logic row_erase_ff;
  logic abort_ff;
  logic permit_ff;
  logic wr_ff;
  logic rd_ff;
  // Data, address and interrupt registers.
  logic [7:0] data_ff;
  logic [7:0] addr_lo_ff;
  logic [dea_pkg::ADDR_HI_BITS-1:0] addr_hi_ff;
  logic wdone_flag_ff;
  logic wdone_en_ff;
  logic wdone_prio_ff;
  // Sequencing state.
  dea_pkg::dea_key_t key_ff;
  dea_pkg::dea_key_t nxt_key;
  logic [dea_pkg::TIMER_W-1:0] timer_ff;
  logic [dea_pkg::TIMER_W-1:0] pwrt_cnt_ff;
  logic pwrt_done_ff;
  logic erase_pend_ff;
  // Bus and status outputs.
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic flash_busy_ff;
  logic config_busy_ff;
  logic irq_req_ff;
  logic irq_prio_ff;

  logic wr_access;
  logic setup;
  logic [7:0] wbyte;
  logic lane0;
  logic hit_ctrl;
  logic hit_key;
  logic hit_data;
  logic hit_lo;
  logic hit_hi;
  logic hit_flags;
  logic hit_en;
  logic hit_prio;
  logic start_req;
  logic start_ok;
  logic start;
  logic bad_start;
  logic done;
  logic array_space;
  logic [dea_pkg::ARRAY_AW-1:0] array_addr;
  logic [7:0] array_rdata;
  logic array_we;
  logic [7:0] array_wdata;
  logic [7:0] ctrl_view;

  // True when the address names one of the mapped registers.
  function automatic logic is_mapped(input logic [dea_pkg::PADDR_W-1:0] a);
    is_mapped = (a == dea_pkg::OFS_CTRL) || (a == dea_pkg::OFS_KEY) ||
                (a == dea_pkg::OFS_DATA) || (a == dea_pkg::OFS_ADDR_LO) ||
                (a == dea_pkg::OFS_ADDR_HI) || (a == dea_pkg::OFS_IRQ_FLAGS) ||
                (a == dea_pkg::OFS_IRQ_EN) || (a == dea_pkg::OFS_IRQ_PRIO);
  endfunction : is_mapped

  // Bus decode; a write takes effect only at the access edge with pready high.
  assign setup = psel && !penable;
  assign wr_access = psel && penable && pready_ff && pwrite;
  assign wbyte = pwdata[7:0];
  assign lane0 = pstrb[0];
  assign hit_ctrl = wr_access && lane0 && (paddr == dea_pkg::OFS_CTRL);
  assign hit_key = wr_access && lane0 && (paddr == dea_pkg::OFS_KEY);
  assign hit_data = wr_access && lane0 && (paddr == dea_pkg::OFS_DATA);
  assign hit_lo = wr_access && lane0 && (paddr == dea_pkg::OFS_ADDR_LO);
  assign hit_hi = wr_access && lane0 && (paddr == dea_pkg::OFS_ADDR_HI);
  assign hit_flags = wr_access && lane0 && (paddr == dea_pkg::OFS_IRQ_FLAGS);
  assign hit_en = wr_access && lane0 && (paddr == dea_pkg::OFS_IRQ_EN);
  assign hit_prio = wr_access && lane0 && (paddr == dea_pkg::OFS_IRQ_PRIO);

  // Array address from the two low bits of the high byte and the low byte.
  assign array_addr = {addr_hi_ff, addr_lo_ff};

  // Data array is targeted only with both space selects clear.
  assign array_space = !cfg_sel_ff && !pgm_sel_ff;

  // Start request, accepted only after the key pair, with permit set beforehand.
  assign start_req = hit_ctrl && wbyte[dea_pkg::BIT_WR] && !wr_ff;
  assign start_ok = (key_ff == dea_pkg::KEY_ARMED) && permit_ff && pwrt_done_ff;
  assign start = start_req && start_ok && !abort_reset;
  assign bad_start = start_req && !start_ok;

  // Self-timed cycle ends when the timer reaches zero.
  assign done = wr_ff && !erase_pend_ff && (timer_ff == '0) && !abort_reset;

  // Erase the byte first, program the new data at the end of the cycle.
  assign array_we = array_space && ((wr_ff && erase_pend_ff && !abort_reset) || done);
  assign array_wdata = erase_pend_ff ? dea_pkg::ERASED_BYTE : data_ff;

  // Read view of the control register; bit 5 reads zero.
  assign ctrl_view = {pgm_sel_ff, cfg_sel_ff, 1'b0, row_erase_ff, abort_ff, permit_ff, wr_ff,
                      rd_ff};

  dea_byte_array #(
    .DEPTH(dea_pkg::ARRAY_DEPTH),
    .AW(dea_pkg::ARRAY_AW)
  ) u_array (
    .pclk(pclk),
    .we(array_we),
    .waddr(array_addr),
    .wdata(array_wdata),
    .raddr(array_addr),
    .rdata(array_rdata)
  );

  // Slave answers in the first access cycle; unmapped addresses give an error.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= '0;
    end
    else
    begin
      pready_ff <= setup;
      pslverr_ff <= setup && !is_mapped(paddr);
      if (setup)
      begin
        unique case (paddr)
          dea_pkg::OFS_CTRL: prdata_ff <= {24'h00_0000, ctrl_view};
          dea_pkg::OFS_DATA: prdata_ff <= {24'h00_0000, data_ff};
          dea_pkg::OFS_ADDR_LO: prdata_ff <= {24'h00_0000, addr_lo_ff};
          dea_pkg::OFS_ADDR_HI: prdata_ff <= {30'h0000_0000, addr_hi_ff};
          dea_pkg::OFS_IRQ_FLAGS: prdata_ff <= {27'h000_0000, wdone_flag_ff, 4'h0};
          dea_pkg::OFS_IRQ_EN: prdata_ff <= {27'h000_0000, wdone_en_ff, 4'h0};
          dea_pkg::OFS_IRQ_PRIO: prdata_ff <= {27'h000_0000, wdone_prio_ff, 4'h0};
          default: prdata_ff <= '0;
        endcase
      end
      else
      begin
        prdata_ff <= '0;
      end
    end
  end

  // Unlock sequence: a key write of 55 restarts it; any other write but the expected next step disarms it.
  always_comb
  begin
    nxt_key = key_ff;
    if (wr_access)
    begin
      unique case (key_ff)
        dea_pkg::KEY_IDLE:
          nxt_key = (hit_key && wbyte == dea_pkg::KEY_FIRST) ? dea_pkg::KEY_HALF :
                    dea_pkg::KEY_IDLE;
        dea_pkg::KEY_HALF:
          nxt_key = (hit_key && wbyte == dea_pkg::KEY_SECOND) ? dea_pkg::KEY_ARMED :
                    (hit_key && wbyte == dea_pkg::KEY_FIRST) ? dea_pkg::KEY_HALF :
                    dea_pkg::KEY_IDLE;
        dea_pkg::KEY_ARMED:
          nxt_key = (hit_key && wbyte == dea_pkg::KEY_FIRST) ? dea_pkg::KEY_HALF :
                    dea_pkg::KEY_IDLE;
        default:
          nxt_key = dea_pkg::KEY_IDLE;
      endcase
    end
    if (abort_reset)
    begin
      nxt_key = dea_pkg::KEY_IDLE;
    end
  end

  // Key state register; the key port itself stores nothing.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      key_ff <= dea_pkg::KEY_IDLE;
    end
    else
    begin
      key_ff <= nxt_key;
    end
  end

  // Power-up timer blocks write starts until it expires.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pwrt_cnt_ff <= '0;
      pwrt_done_ff <= 1'b0;
    end
    else if (!pwrt_done_ff)
    begin
      pwrt_cnt_ff <= pwrt_cnt_ff + 1'b1;
      pwrt_done_ff <= (pwrt_cnt_ff == dea_pkg::TIMER_W'(PWRT_CYCLES - 1));
    end
  end

  // Self-timed write: one erase cycle, then a countdown, then programming.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wr_ff <= 1'b0;
      erase_pend_ff <= 1'b0;
      timer_ff <= '0;
    end
    else if (abort_reset)
    begin
      wr_ff <= 1'b0;
      erase_pend_ff <= 1'b0;
      timer_ff <= '0;
    end
    else if (start)
    begin
      wr_ff <= 1'b1;
      erase_pend_ff <= 1'b1;
      timer_ff <= dea_pkg::TIMER_W'(WRITE_CYCLES - 1);
    end
    else if (wr_ff)
    begin
      erase_pend_ff <= 1'b0;
      if (!erase_pend_ff && timer_ff != '0)
      begin
        timer_ff <= timer_ff - 1'b1;
      end
      if (done)
      begin
        wr_ff <= 1'b0;
      end
    end
  end

  // Control fields; locked while a write runs, selects never touched by an abort.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pgm_sel_ff <= 1'b0;
      cfg_sel_ff <= 1'b0;
      row_erase_ff <= 1'b0;
      permit_ff <= 1'b0;
    end
    else if (hit_ctrl && !wr_ff)
    begin
      pgm_sel_ff <= wbyte[dea_pkg::BIT_PGM_SEL];
      cfg_sel_ff <= wbyte[dea_pkg::BIT_CFG_SEL];
      row_erase_ff <= wbyte[dea_pkg::BIT_ROW_ERASE];
      permit_ff <= wbyte[dea_pkg::BIT_PERMIT];
    end
    else if (done && pgm_sel_ff && !cfg_sel_ff)
    begin
      row_erase_ff <= 1'b0;
    end
  end

  // Abort flag: set by cut-short or improper writes, cleared by a completed write.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      abort_ff <= 1'b0;
    end
    else if ((abort_reset && wr_ff) || bad_start)
    begin
      abort_ff <= 1'b1;
    end
    else if (done)
    begin
      abort_ff <= 1'b0;
    end
    else if (hit_ctrl && !wr_ff)
    begin
      abort_ff <= wbyte[dea_pkg::BIT_ABORT];
    end
  end

  // Read start accepted only for the data array, completes in one cycle.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rd_ff <= 1'b0;
    end
    else
    begin
      rd_ff <= hit_ctrl && !wr_ff && wbyte[dea_pkg::BIT_RD] &&
               !wbyte[dea_pkg::BIT_PGM_SEL] && !wbyte[dea_pkg::BIT_CFG_SEL];
    end
  end

  // Data byte: loaded by a read one cycle after start, or by software when idle.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      data_ff <= dea_pkg::RST_BYTE;
    end
    else if (rd_ff)
    begin
      data_ff <= array_rdata;
    end
    else if (hit_data && !wr_ff)
    begin
      data_ff <= wbyte;
    end
  end

  // Address pair; the upper six bits of the high byte are not stored.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      addr_lo_ff <= dea_pkg::RST_BYTE;
      addr_hi_ff <= '0;
    end
    else if (!wr_ff)
    begin
      if (hit_lo)
      begin
        addr_lo_ff <= wbyte;
      end
      if (hit_hi)
      begin
        addr_hi_ff <= wbyte[dea_pkg::ADDR_HI_BITS-1:0];
      end
    end
  end

  // Write-done flag: completion wins over a software clear in the same cycle.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wdone_flag_ff <= 1'b0;
    end
    else if (done)
    begin
      wdone_flag_ff <= 1'b1;
    end
    else if (hit_flags)
    begin
      wdone_flag_ff <= wbyte[dea_pkg::BIT_WDONE];
    end
  end

  // Interrupt enable and priority bits.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wdone_en_ff <= 1'b0;
      wdone_prio_ff <= 1'b0;
    end
    else
    begin
      if (hit_en)
      begin
        wdone_en_ff <= wbyte[dea_pkg::BIT_WDONE];
      end
      if (hit_prio)
      begin
        wdone_prio_ff <= wbyte[dea_pkg::BIT_WDONE];
      end
    end
  end

  // Registered status outputs: space in use, interrupt request and its level.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      flash_busy_ff <= 1'b0;
      config_busy_ff <= 1'b0;
      irq_req_ff <= 1'b0;
      irq_prio_ff <= 1'b0;
    end
    else
    begin
      flash_busy_ff <= wr_ff && pgm_sel_ff && !cfg_sel_ff;
      config_busy_ff <= wr_ff && cfg_sel_ff;
      irq_req_ff <= wdone_flag_ff && wdone_en_ff;
      irq_prio_ff <= wdone_prio_ff;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign flash_op_busy = flash_busy_ff;
  assign config_op_busy = config_busy_ff;
  assign row_erase_active = row_erase_ff;
  assign irq_req = irq_req_ff;
  assign irq_high_prio = irq_prio_ff;

endmodule : dea_ctrl

// ### rtl/dea_pkg.sv
// Shared constants for the data array access controller.
package dea_pkg;

  // Register bus width and register byte offsets.
  localparam int unsigned PADDR_W = 12;
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_KEY = 12'h004;
  localparam logic [11:0] OFS_DATA = 12'h008;
  localparam logic [11:0] OFS_ADDR_LO = 12'h00C;
  localparam logic [11:0] OFS_ADDR_HI = 12'h010;
  localparam logic [11:0] OFS_IRQ_FLAGS = 12'h014;
  localparam logic [11:0] OFS_IRQ_EN = 12'h018;
  localparam logic [11:0] OFS_IRQ_PRIO = 12'h01C;

  // Field positions of the memory access control register.
  localparam int unsigned BIT_RD = 0;
  localparam int unsigned BIT_WR = 1;
  localparam int unsigned BIT_PERMIT = 2;
  localparam int unsigned BIT_ABORT = 3;
  localparam int unsigned BIT_ROW_ERASE = 4;
  localparam int unsigned BIT_CFG_SEL = 6;
  localparam int unsigned BIT_PGM_SEL = 7;

  // Field position of the write-done bit in the three peripheral interrupt registers.
  localparam int unsigned BIT_WDONE = 4;

  // Array geometry.
  localparam int unsigned ARRAY_DEPTH = 1024;
  localparam int unsigned ARRAY_AW = 10;
  localparam int unsigned ADDR_HI_BITS = 2;

  // Unlock key values and the value of an erased byte.
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;

  // Values after reset.
  localparam logic [7:0] RST_BYTE = 8'h00;

  // Timing: clock rate, self-timed write and power-up timer.
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned WRITE_TIME_US = 4;
  localparam int unsigned WRITE_CYCLES = (WRITE_TIME_US * (CLK_HZ / 1_000_000) > 0) ?
                                         WRITE_TIME_US * (CLK_HZ / 1_000_000) : 1;
  localparam int unsigned PWRT_TIME_US = 64;
  localparam int unsigned PWRT_CYCLES = (PWRT_TIME_US * (CLK_HZ / 1_000_000) > 0) ?
                                        PWRT_TIME_US * (CLK_HZ / 1_000_000) : 1;
  localparam int unsigned TIMER_W = 24;

  // Progress through the unlock key sequence.
  typedef enum logic [1:0]
  {
    KEY_IDLE = 2'b00,
    KEY_HALF = 2'b01,
    KEY_ARMED = 2'b10
  } dea_key_t;

endpackage : dea_pkg

// ### rtl/dea_byte_array.sv
// Byte-wide storage array held in flip-flops, one write port and one read port.
module dea_byte_array #(
  parameter int unsigned DEPTH = dea_pkg::ARRAY_DEPTH,
  parameter int unsigned AW = dea_pkg::ARRAY_AW
) (
  input wire logic pclk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [7:0] rdata
);

  logic [7:0] mem [DEPTH];

  // Storage is nonvolatile in intent, so it carries no reset.
  always_ff @(posedge pclk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
  end

  // Read is combinational; the controller registers it.
  assign rdata = mem[raddr];

endmodule : dea_byte_array

// ### tb/dea_ctrl_assertions.sv
// Checker of bus timing and write sequencing at the controller's ports.
module dea_ctrl_checker #(
  parameter int unsigned WRITE_CYCLES = dea_pkg::WRITE_CYCLES,
  parameter int unsigned PWRT_CYCLES = dea_pkg::PWRT_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [dea_pkg::PADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic flash_op_busy,
  input wire logic config_op_busy,
  input wire logic irq_req
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] busy_cnt_ff;
  logic [15:0] up_cnt_ff;
  logic any_busy;
  logic ctrl_start;

  // A write-start request is a completed control write with bit 1 set.
  assign any_busy = flash_op_busy | config_op_busy;
  assign ctrl_start = psel & penable & pready & pwrite & pwdata[1] & (paddr == dea_pkg::OFS_CTRL);

  // Length of the current busy run and cycles since reset release.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      busy_cnt_ff <= 16'h0000;
      up_cnt_ff <= 16'h0000;
    end
    else
    begin
      busy_cnt_ff <= any_busy ? busy_cnt_ff + 16'h0001 : 16'h0000;
      if (up_cnt_ff != 16'hFFFF)
        up_cnt_ff <= up_cnt_ff + 16'h0001;
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_err_with_ready: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
    else $error("pslverr without pready or with data");
  a_key_reads_zero: assert property (
    psel && !penable && !pwrite && paddr == dea_pkg::OFS_KEY |=> prdata == 32'h0000_0000)
    else $error("key register read not zero");
  a_upper_bytes_zero: assert property (prdata[31:8] == 24'h00_0000 && (pready || prdata == 0))
    else $error("read data outside access or above byte");
  a_one_space_busy: assert property (!(flash_op_busy && config_op_busy))
    else $error("both space busy flags high");
  a_busy_is_timed: assert property (busy_cnt_ff <= WRITE_CYCLES + 2)
    else $error("write runs longer than its timer");
  a_pwrt_no_start: assert property (up_cnt_ff < PWRT_CYCLES |-> !any_busy)
    else $error("write started during power-up time");
  a_busy_from_start: assert property (
    $rose(any_busy) |-> $past(ctrl_start) || $past(ctrl_start, 2))
    else $error("busy without a write-start request");

  cover property ($rose(flash_op_busy));
  cover property ($rose(config_op_busy));
  cover property (pslverr);
  cover property ($rose(irq_req));
endmodule : dea_ctrl_checker

bind dea_ctrl dea_ctrl_checker #(.WRITE_CYCLES(WRITE_CYCLES), .PWRT_CYCLES(PWRT_CYCLES)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .flash_op_busy(flash_op_busy), .config_op_busy(config_op_busy), .irq_req(irq_req)
);

// ### tb/dea_fw_model.sv
// Firmware model: an APB master that issues single register accesses.
module dea_fw_model (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [dea_pkg::PADDR_W-1:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 1ps;

  // The bus starts idle; all byte lanes are always enabled.
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'hF;
  end

  // Setup cycle, then the access held until pready is seen at an edge.
  task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d,
    output logic [7:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    q = prdata[7:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : dea_fw_model

// ### tb/dea_ctrl_tb.sv
// Self-checking bench for the data array access controller.
module dea_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] CT = dea_pkg::OFS_CTRL;
  localparam logic [11:0] KY = dea_pkg::OFS_KEY;
  localparam logic [11:0] DT = dea_pkg::OFS_DATA;
  localparam logic [11:0] AL = dea_pkg::OFS_ADDR_LO;
  localparam logic [11:0] AH = dea_pkg::OFS_ADDR_HI;
  localparam logic [11:0] FL = dea_pkg::OFS_IRQ_FLAGS;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic abort_reset = 1'b0;
  logic psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic flash_op_busy, config_op_busy, row_erase_active, irq_req, irq_high_prio;
  int bad_count = 0;
  int compares = 0;
  int cycles = 0;

  // Clock and a cycle ceiling that cuts a hang short.
  always #5 pclk = ~pclk;
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      bad_count++;
      report_and_stop();
    end
  end

  dea_ctrl #(.WRITE_CYCLES(20), .PWRT_CYCLES(60)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .abort_reset(abort_reset), .flash_op_busy(flash_op_busy),
    .config_op_busy(config_op_busy), .row_erase_active(row_erase_active),
    .irq_req(irq_req), .irq_high_prio(irq_high_prio));

  dea_fw_model fw (
    .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  task automatic report_and_stop;
    if (bad_count == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [7:0] got, input logic [7:0] want);
    compares++;
    if (got !== want)
    begin
      bad_count++;
      $display("[ERR] t=%0t got %h want %h", $time, got, want);
    end
  endtask : chk

  task automatic chk_bit(input logic got, input logic want);
    chk({7'h00, got}, {7'h00, want});
  endtask : chk_bit

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic e;
    fw.xfer(1'b1, a, d, q, e);
  endtask : wr

  task automatic chk_regm(input logic [11:0] a, input logic [7:0] m, input logic [7:0] want);
    logic [7:0] q;
    logic e;
    fw.xfer(1'b0, a, 8'h00, q, e);
    chk(q & m, want);
  endtask : chk_regm

  task automatic chk_reg(input logic [11:0] a, input logic [7:0] want);
    chk_regm(a, 8'hFF, want);
  endtask : chk_reg

  // Key pair followed at once by the control write that starts the cycle.
  task automatic unlock_start(input logic [7:0] v);
    wr(KY, dea_pkg::KEY_FIRST);
    wr(KY, dea_pkg::KEY_SECOND);
    wr(CT, v);
  endtask : unlock_start

  // Firmware read: address pair, both selects clear with read start, then the data byte.
  task automatic rd_array(input logic [9:0] a, input logic [7:0] want);
    wr(AH, {6'h3F, a[9:8]});
    wr(AL, a[7:0]);
    wr(CT, 8'h01);
    chk_reg(DT, want);
  endtask : rd_array

  task automatic wait_idle;
    logic [7:0] q;
    logic e;
    int n;
    n = 0;
    q = 8'h02;
    while (q[1] !== 1'b0 && n < 40)
    begin
      fw.xfer(1'b0, CT, 8'h00, q, e);
      n++;
    end
    chk_bit(q[1], 1'b0);
  endtask : wait_idle

  task automatic t_power_up;
    logic [7:0] q;
    logic e;
    chk_reg(CT, 8'h00);
    chk_reg(DT, 8'h00);
    chk_reg(AH, 8'h00);
    chk_reg(KY, 8'h00);
    chk_bit(irq_req, 1'b0);
    chk_bit(irq_high_prio, 1'b0);
    fw.xfer(1'b0, 12'h020, 8'h00, q, e);
    chk_bit(e, 1'b1);
    chk(q, 8'h00);
    wr(CT, 8'h04);
    unlock_start(8'h06);
    chk_reg(CT, 8'h0C);
    wr(CT, 8'h00);
    repeat (60) @(posedge pclk);
  endtask : t_power_up

  task automatic t_write_read(input logic [9:0] a, input logic [7:0] d);
    wr(AH, {6'h3F, a[9:8]});
    chk_reg(AH, {6'h00, a[9:8]});
    wr(AL, a[7:0]);
    wr(DT, d);
    wr(dea_pkg::OFS_IRQ_EN, 8'h10);
    wr(dea_pkg::OFS_IRQ_PRIO, 8'h10);
    wr(CT, 8'h04);
    unlock_start(8'h06);
    chk_reg(CT, 8'h06);
    wr(CT, 8'h04);
    wr(AL, ~a[7:0]);
    wr(DT, ~d);
    chk_reg(AL, a[7:0]);
    chk_reg(DT, d);
    wait_idle();
    chk_reg(CT, 8'h04);
    chk_reg(FL, 8'h10);
    chk_bit(irq_req, 1'b1);
    chk_bit(irq_high_prio, 1'b1);
    rd_array(a, d);
    wr(FL, 8'h00);
    chk_reg(FL, 8'h00);
    chk_bit(irq_req, 1'b0);
  endtask : t_write_read

  task automatic t_refused;
    rd_array(10'h3FF, 8'hA5);
    wr(CT, 8'h04);
    wr(KY, 8'hAA);
    wr(KY, 8'h55);
    wr(CT, 8'h06);
    chk_reg(CT, 8'h0C);
    wr(CT, 8'h00);
    unlock_start(8'h06);
    chk_regm(CT, 8'h0B, 8'h08);
    chk_reg(FL, 8'h00);
    wr(DT, 8'h3C);
    for (int i = 0; i < 2; i++)
    begin
      wr(CT, (i == 0) ? 8'h81 : 8'h41);
      chk_regm(CT, 8'h01, 8'h00);
      chk_reg(DT, 8'h3C);
    end
  endtask : t_refused

  task automatic t_spaces;
    logic [7:0] v;
    for (int i = 0; i < 3; i++)
    begin
      v = (i == 0) ? 8'h84 : (i == 1) ? 8'h94 : 8'h44;
      wr(CT, v);
      repeat (2) @(posedge pclk);
      chk_bit(row_erase_active, v[4]);
      unlock_start(v | 8'h02);
      repeat (2) @(posedge pclk);
      chk_bit(flash_op_busy, v[7] & ~v[6]);
      chk_bit(config_op_busy, v[6]);
      wait_idle();
      chk_reg(CT, v & 8'hEF);
      chk_reg(FL, 8'h10);
      wr(FL, 8'h00);
    end
    // The non-array writes above pointed at 3FF with 3C staged; the array must keep A5.
    rd_array(10'h3FF, 8'hA5);
  endtask : t_spaces

  task automatic t_abort;
    wr(CT, 8'h84);
    unlock_start(8'h86);
    @(posedge pclk);
    abort_reset <= 1'b1;
    @(posedge pclk);
    abort_reset <= 1'b0;
    repeat (2) @(posedge pclk);
    chk_bit(flash_op_busy, 1'b0);
    chk_regm(CT, 8'hCB, 8'h88);
    chk_reg(FL, 8'h00);
  endtask : t_abort

  initial
  begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_power_up();
    t_write_read(10'h3FF, 8'hA5);
    t_write_read(10'h000, 8'h5A);
    t_refused();
    t_spaces();
    t_abort();
    report_and_stop();
  end
endmodule : dea_ctrl_tb
